// ===== pkg/opa_pkg.sv
// Shared constants and types of the OSD preamp serial register port.
// Assumes one system clock domain and one serial link clock domain.
`default_nettype none

package opa_pkg;

    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    // Address byte on the wire: 0xBA write, 0xBB read
    localparam logic [6:0]  OPA_SLV_ADDR  = 7'h5D;
    localparam int          OPA_RW_BIT    = 0;
    localparam logic [3:0]  OPA_BIT_LAST  = 4'h7;
    localparam logic [3:0]  OPA_BIT_ACK   = 4'h8;
    localparam logic [3:0]  OPA_BIT_FIRST = 4'h1;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] OPA_FONT_HI   = 16'h3FFF;
    localparam logic [15:0] OPA_RSV_HI    = 16'h7FFF;
    localparam logic [15:0] OPA_PAGE_LO   = 16'h8000;
    localparam logic [15:0] OPA_PAGE_HI   = 16'h81FF;
    localparam logic [15:0] OPA_CTRL_ADDR = 16'h8402;
    localparam logic [15:0] OPA_PTR_RST   = 16'h0000;
    localparam logic [15:0] OPA_PTR_STEP  = 16'h0001;

    // font_plane_select register
    localparam logic [1:0]  OPA_CTRL_RST  = 2'h0;
    localparam int          OPA_CTRL_FONT = 0;
    localparam int          OPA_CTRL_ATTR = 1;

    // ------------------------------------------------------------
    // Font address fields and page memory
    // ------------------------------------------------------------
    localparam int          OPA_ROM_AW    = 14;
    localparam int          OPA_CODE_MSB  = 13;
    localparam int          OPA_CODE_LSB  = 6;
    localparam int          OPA_ROW_MSB   = 5;
    localparam int          OPA_ROW_LSB   = 1;
    localparam int          OPA_HALF_BIT  = 0;
    localparam logic [4:0]  OPA_ROW_MAX   = 5'h11;
    localparam logic [7:0]  OPA_CODE4_MIN = 8'hC0;
    localparam int          OPA_PIX_W     = 12;
    localparam int          OPA_PAGE_AW   = 9;
    localparam int          OPA_DW        = 8;
    localparam logic [7:0]  OPA_BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PLO, ST_PHI, ST_WDATA, ST_RDATA
    } opa_link_st_t;

    typedef enum logic [1:0] {WK_PLO, WK_PHI, WK_DATA} opa_wr_kind_t;

    typedef enum logic [1:0] {RG_FONT, RG_PAGE, RG_CTRL, RG_NONE} opa_region_t;

    typedef struct packed {
        opa_wr_kind_t kind;
        logic [7:0]   data;
    } opa_wr_word_t;

endpackage : opa_pkg

`default_nettype wire

// ===== hw/opa_page_ram.sv
// Display page memory, one byte per entry, registered read port.
// Assumes a single clock; write and read share one address.
`timescale 1ns/1ps
`default_nettype none

module opa_page_ram
    import opa_pkg::*;
#(
    parameter int AW = OPA_PAGE_AW,
    parameter int DW = OPA_DW
) (
    input  wire logic          clk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end

    // Read after write returns the new byte one cycle later
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata <= mem[addr];
        end
    end

endmodule : opa_page_ram

`default_nettype wire

// ===== hw/opa_font_rom.sv
// Character font store, two-colour and four-colour ranges.
// Assumes the caller gives the low 14 pointer bits and the plane bit.
`timescale 1ns/1ps
`default_nettype none

module opa_font_rom
    import opa_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic [OPA_ROM_AW-1:0] addr,
    input  wire logic                  plane,
    output logic      [OPA_DW-1:0]     rdata
);

    // ------------------------------------------------------------
    // Glyph source
    // ------------------------------------------------------------
    // Stand-in glyph pattern; the real mask contents replace it.
    // Bit 0 is the leftmost pixel of the row.
    function automatic logic [OPA_PIX_W-1:0] glyph_row(
        input logic [7:0] code,
        input logic [4:0] row,
        input logic       pl
    );
        logic [OPA_PIX_W-1:0] px;
        px = {code[3:0], code} ^ {7'h00, row};
        if (pl && code >= OPA_CODE4_MIN) begin
            px = ~px;
        end
        return px;
    endfunction : glyph_row

    logic [7:0]           code;
    logic [4:0]           row;
    logic [OPA_PIX_W-1:0] px;

    assign code = addr[OPA_CODE_MSB:OPA_CODE_LSB];
    assign row  = addr[OPA_ROW_MSB:OPA_ROW_LSB];
    assign px   = glyph_row(code, row, plane);

    // Rows past the last one read as zero; upper nibble of the high
    // byte has no pixels behind it and reads as zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= OPA_BYTE_ZERO;
        end else if (ce) begin
            if (row > OPA_ROW_MAX) begin
                rdata <= OPA_BYTE_ZERO;
            end else if (addr[OPA_HALF_BIT]) begin
                rdata <= {4'h0, px[OPA_PIX_W-1:OPA_DW]};
            end else begin
                rdata <= px[OPA_DW-1:0];
            end
        end
    end

endmodule : opa_font_rom

`default_nettype wire

// ===== hw/opa_i2c_access.sv
// Two-wire slave port into the OSD preamp address space.
// Assumes the serial clock is a clock port and sda is open drain.
//
// How it works
// - Address byte holds seven address bits then the direction bit.
// - Direction bit low means write, high means read.
// - Each received byte is acknowledged by pulling sda low, the address byte only when it matches.
// - Write address is followed by pointer, low byte then high.
// - Each written data byte lands at the pointer only in page memory or control, and the pointer then steps.
// - Reads start at the stored pointer and step after each byte.
// - After a read address the device shifts out eight data bits.
// - Two-colour font at 0x0000-0x2FFF, four-colour at 0x3000-0x3FFF.
// - Font address: code in 13..6, row in 5..1, half in 0.
// - Codes 00-BF two-colour, C0-FF four-colour.
// - Low byte pixels 0-7 leftmost first; high byte pixels 8-11.
// - Control bit 0 picks the four-colour font plane.
// - Page memory at 0x8000-0x81FF, 512 entries, read and write.
// - Control bit 1 attribute, bit 0 font plane, resets to zero.
`timescale 1ns/1ps
`default_nettype none

module opa_i2c_access
    import opa_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic scl_clk,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      font_plane_sel,
    output logic      font_attr_sel
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    opa_link_st_t st_r;
    opa_link_st_t st_nxt;
    logic [3:0]   cnt_r;
    logic [6:0]   sh_r;
    logic [7:0]   byte_w;
    logic         byte_done;
    logic         ack_r;
    logic         rw_r;
    logic         start_tgl_r;
    logic         start_seen_r;
    logic         new_start;
    logic         wr_tgl_r;
    logic         rd_tgl_r;
    opa_wr_word_t wr_word_r;
    logic [7:0]   tx_r;

    logic [2:0]   wr_sync_r;
    logic [2:0]   rd_sync_r;
    logic         wr_evt;
    logic         rd_evt;
    logic [15:0]  ptr_r;
    logic [15:0]  ptr_d_r;
    logic [1:0]   ctrl_r;
    logic [7:0]   rd_data_r;
    logic [7:0]   ram_q;
    logic [7:0]   rom_q;
    logic         ram_we;
    logic         data_evt;

    function automatic opa_region_t region(input logic [15:0] a);
        if (a <= OPA_FONT_HI) begin
            return RG_FONT;
        end else if (a >= OPA_PAGE_LO && a <= OPA_PAGE_HI) begin
            return RG_PAGE;
        end else if (a == OPA_CTRL_ADDR) begin
            return RG_CTRL;
        end
        return RG_NONE;
    endfunction : region

    // ------------------------------------------------------------
    // Start detection
    // ------------------------------------------------------------
    // Clocked by sda itself since scl stands high across a start;
    // the link reset is asynchronous because scl may not run at reset.
    always_ff @(negedge sda_in or posedge sys_rst) begin
        if (sys_rst) begin
            start_tgl_r <= 1'b0;
        end else if (scl_clk) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    assign new_start = start_tgl_r ^ start_seen_r;
    assign byte_w    = {sh_r, sda_in};
    assign byte_done = !new_start && st_r != ST_IDLE
                       && cnt_r == OPA_BIT_LAST;

    // ------------------------------------------------------------
    // Link receive side, rising scl
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE:  st_nxt = ST_IDLE;
            ST_ADDR:  st_nxt = !ack_r ? ST_IDLE
                             : (rw_r ? ST_RDATA : ST_PLO);
            ST_PLO:   st_nxt = ST_PHI;
            ST_PHI:   st_nxt = ST_WDATA;
            ST_WDATA: st_nxt = ST_WDATA;
            ST_RDATA: st_nxt = sda_in ? ST_IDLE : ST_RDATA;
        endcase
    end

    always_ff @(posedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r         <= ST_IDLE;
            cnt_r        <= 4'h0;
            sh_r         <= 7'h00;
            ack_r        <= 1'b0;
            rw_r         <= 1'b0;
            start_seen_r <= 1'b0;
        end else begin
            start_seen_r <= start_tgl_r;
            if (new_start) begin
                st_r  <= ST_ADDR;
                cnt_r <= OPA_BIT_FIRST;
                sh_r  <= {sh_r[5:0], sda_in};
                ack_r <= 1'b0;
            end else if (st_r != ST_IDLE) begin
                if (cnt_r == OPA_BIT_LAST) begin
                    cnt_r <= OPA_BIT_ACK;
                    if (st_r == ST_ADDR) begin
                        ack_r <= byte_w[7:1] == OPA_SLV_ADDR;
                        rw_r  <= byte_w[OPA_RW_BIT];
                    end else begin
                        ack_r <= st_r != ST_RDATA;
                    end
                end else if (cnt_r == OPA_BIT_ACK) begin
                    cnt_r <= 4'h0;
                    st_r  <= st_nxt;
                end else begin
                    sh_r  <= byte_w[6:0];
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end

    // Received bytes cross as a stable word plus a toggle
    always_ff @(posedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_tgl_r  <= 1'b0;
            wr_word_r <= '{kind: WK_PLO, data: 8'h00};
        end else if (byte_done && st_r inside {ST_PLO, ST_PHI, ST_WDATA}) begin
            wr_tgl_r       <= ~wr_tgl_r;
            wr_word_r.data <= byte_w;
            unique case (st_r)
                ST_PLO:  wr_word_r.kind <= WK_PLO;
                ST_PHI:  wr_word_r.kind <= WK_PHI;
                default: wr_word_r.kind <= WK_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link drive side, falling scl
    // ------------------------------------------------------------
    // Read data is fetched ahead; each load asks for the next byte so
    // the system side has a whole byte time to refill.
    always_ff @(negedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_oe   <= 1'b0;
            tx_r     <= 8'h00;
            rd_tgl_r <= 1'b0;
        end else if (cnt_r == OPA_BIT_ACK && ack_r) begin
            sda_oe <= 1'b1;
        end else if (st_r == ST_RDATA && cnt_r == 4'h0) begin
            tx_r     <= {rd_data_r[6:0], 1'b0};
            sda_oe   <= ~rd_data_r[7];
            rd_tgl_r <= ~rd_tgl_r;
        end else if (st_r == ST_RDATA && cnt_r < OPA_BIT_ACK) begin
            sda_oe <= ~tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // Open drain: only ever drives low
    always_ff @(negedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_sync_r <= 3'h0;
            rd_sync_r <= 3'h0;
        end else if (ce) begin
            wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
            rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
        end
    end

    assign wr_evt   = ce && (wr_sync_r[2] ^ wr_sync_r[1]);
    assign rd_evt   = ce && (rd_sync_r[2] ^ rd_sync_r[1]);
    assign data_evt = wr_evt && wr_word_r.kind == WK_DATA;
    assign ram_we   = data_evt && region(ptr_r) == RG_PAGE;

    // ------------------------------------------------------------
    // Address pointer
    // ------------------------------------------------------------
    // Pointer survives stop, so a later read resumes where it points.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_r <= OPA_PTR_RST;
        end else if (wr_evt) begin
            unique case (wr_word_r.kind)
                WK_PLO:  ptr_r[7:0]  <= wr_word_r.data;
                WK_PHI:  ptr_r[15:8] <= wr_word_r.data;
                WK_DATA: ptr_r       <= ptr_r + OPA_PTR_STEP;
            endcase
        end else if (rd_evt) begin
            ptr_r <= ptr_r + OPA_PTR_STEP;
        end
    end

    // ------------------------------------------------------------
    // font_plane_select register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= OPA_CTRL_RST;
        end else if (data_evt && region(ptr_r) == RG_CTRL) begin
            ctrl_r <= wr_word_r.data[1:0];
        end
    end

    assign font_plane_sel = ctrl_r[OPA_CTRL_FONT];
    assign font_attr_sel  = ctrl_r[OPA_CTRL_ATTR];

    // ------------------------------------------------------------
    // Read fetch
    // ------------------------------------------------------------
    opa_page_ram u_page_ram (
        .clk   (clk),
        .ce    (ce),
        .we    (ram_we),
        .addr  (ptr_r[OPA_PAGE_AW-1:0]),
        .wdata (wr_word_r.data),
        .rdata (ram_q)
    );

    opa_font_rom u_font_rom (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .addr    (ptr_r[OPA_ROM_AW-1:0]),
        .plane   (ctrl_r[OPA_CTRL_FONT]),
        .rdata   (rom_q)
    );

    // Refreshed every cycle, so the byte is current well before the
    // link loads it; reserved space reads as zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_d_r   <= OPA_PTR_RST;
            rd_data_r <= OPA_BYTE_ZERO;
        end else if (ce) begin
            ptr_d_r <= ptr_r;
            unique case (region(ptr_d_r))
                RG_FONT: rd_data_r <= rom_q;
                RG_PAGE: rd_data_r <= ram_q;
                RG_CTRL: rd_data_r <= {6'h00, ctrl_r};
                RG_NONE: rd_data_r <= OPA_BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ptr_lo;
        @(posedge clk) disable iff (sys_rst)
        (wr_evt && wr_word_r.kind == WK_PLO)
            |=> ptr_r[7:0] == $past(wr_word_r.data);
    endproperty
    a_ptr_lo: assert property (p_ptr_lo)
        else $error("pointer low byte not loaded");

    property p_ptr_data;
        @(posedge clk) disable iff (sys_rst)
        data_evt |=> ptr_r == $past(ptr_r) + OPA_PTR_STEP;
    endproperty
    a_ptr_data: assert property (p_ptr_data)
        else $error("pointer did not step after data byte");

    property p_ptr_rd;
        @(posedge clk) disable iff (sys_rst)
        (rd_evt && !wr_evt) |=> ptr_r == $past(ptr_r) + OPA_PTR_STEP;
    endproperty
    a_ptr_rd: assert property (p_ptr_rd)
        else $error("pointer did not step after read byte");

    property p_ctrl_wr;
        @(posedge clk) disable iff (sys_rst)
        (data_evt && ptr_r == OPA_CTRL_ADDR)
            |=> font_plane_sel == $past(wr_word_r.data[0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("plane select not written");

    property p_discard;
        @(posedge clk) disable iff (sys_rst)
        (data_evt && ptr_r <= OPA_RSV_HI) |-> !ram_we ##1 $stable(ctrl_r);
    endproperty
    a_discard: assert property (p_discard)
        else $error("write into read-only range took effect");

    property p_page_rd;
        @(posedge clk) disable iff (sys_rst)
        (ce && region(ptr_d_r) == RG_PAGE) |=> rd_data_r == $past(ram_q);
    endproperty
    a_page_rd: assert property (p_page_rd)
        else $error("page read data wrong");

    property p_nack_addr;
        @(posedge scl_clk) disable iff (sys_rst)
        (byte_done && st_r == ST_ADDR && byte_w[7:1] != OPA_SLV_ADDR)
            |=> !ack_r ##1 (st_r == ST_IDLE || new_start);
    endproperty
    a_nack_addr: assert property (p_nack_addr)
        else $error("foreign address acknowledged");

    property p_dir_rd;
        @(posedge scl_clk) disable iff (sys_rst)
        (byte_done && st_r == ST_ADDR && byte_w == {OPA_SLV_ADDR, 1'b1})
            ##1 !new_start |=> st_r == ST_RDATA || new_start;
    endproperty
    a_dir_rd: assert property (p_dir_rd)
        else $error("read address did not enter read state");

    property p_ack_rx;
        @(negedge scl_clk) disable iff (sys_rst)
        (cnt_r == OPA_BIT_ACK && st_r inside {ST_PLO, ST_PHI, ST_WDATA})
            |=> sda_oe;
    endproperty
    a_ack_rx: assert property (p_ack_rx)
        else $error("received byte not acknowledged");

    property p_rd_drive;
        @(negedge scl_clk) disable iff (sys_rst)
        (st_r == ST_RDATA && cnt_r == 4'h0)
            |=> sda_oe == !$past(rd_data_r[7]);
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("first read bit not driven");

endmodule : opa_i2c_access

`default_nettype wire

// ===== tb/opa_i2c_master.sv
// Two-wire bus master model that faces the OSD preamp serial port.
// Assumes a pull-up on sda; the bench resolves the wire level.
`timescale 1ns/1ps
`default_nettype none

module opa_i2c_master (
    output var logic scl,
    output var logic sda_o,
    input  wire logic sda
);
    localparam int HALF = 32;
    localparam int GAP  = 1200;
    localparam int SKEW = 4;

    // Bus idle: scl stands high and sda is released between frames
    initial begin
        scl   = 1'b1;
        sda_o = 1'b1;
    end

    task automatic start();
        sda_o = 1'b0;
        #HALF scl = 1'b0;
    endtask : start

    task automatic stop();
        #SKEW sda_o = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_o = 1'b1;
        #HALF;
    endtask : stop

    // -----------------------------------------------------------
    // One byte and its acknowledge slot
    // -----------------------------------------------------------
    // Sda moves a little after scl falls so no false start or stop
    task automatic xfer(input logic [7:0] tx, input logic abit,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #SKEW sda_o = tx[i];
            #(HALF - SKEW) scl = 1'b1;
            rx[i] = sda;
            #HALF scl = 1'b0;
        end
        #SKEW sda_o = abit;
        #(HALF - SKEW) scl = 1'b1;
        ack = ~sda;
        // Long high ack phase leaves the system side time to fetch data
        #GAP scl = 1'b0;
    endtask : xfer
endmodule : opa_i2c_master

`default_nettype wire

// ===== tb/opa_i2c_access_tb.sv
// Self-checking bench of the OSD preamp two-wire register port.
// Assumes the master model opa_i2c_master and a pull-up on sda.
`timescale 1ns/1ps
`default_nettype none

module opa_i2c_access_tb
    import opa_pkg::*;
;
    logic       clk, sys_rst, scl, m_sda, sda_out, sda_oe;
    logic       plane_sel, attr_sel, ack;
    logic [7:0] rx;
    logic [7:0] page_m [512];
    logic [1:0] ctrl_m;
    wire        sda;
    int         fail_count, check_count, seed;

    assign sda = m_sda & (sda_oe ? sda_out : 1'b1);

    opa_i2c_access i_opa_i2c_access (
        .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .scl_clk(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .font_plane_sel(plane_sel), .font_attr_sel(attr_sel));
    opa_i2c_master i_opa_i2c_master (.scl(scl), .sda_o(m_sda), .sda(sda));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // -----------------------------------------------------------
    // Expectations, checks and transfers
    // -----------------------------------------------------------
    function automatic logic [7:0] exp_byte(input logic [15:0] a);
        logic [11:0] px;
        px = {a[9:6], a[13:6]} ^ {7'h00, a[5:1]};
        if (a[13:12] == 2'b11 && ctrl_m[0]) px = ~px;
        if (a <= OPA_FONT_HI)
            return (a[5:1] > 5'h11) ? 8'h00
                 : (a[0] ? {4'h0, px[11:8]} : px[7:0]);
        if (a >= OPA_PAGE_LO && a <= OPA_PAGE_HI) return page_m[a[8:0]];
        if (a == OPA_CTRL_ADDR) return {6'h00, ctrl_m};
        return 8'h00;
    endfunction : exp_byte

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic put(input logic [7:0] b, input logic exp_ack);
        i_opa_i2c_master.xfer(b, 1'b1, rx, ack);
        chk("ack", {7'h00, exp_ack}, {7'h00, ack});
    endtask : put

    task automatic wr(input logic [15:0] a, input logic [7:0] d[$]);
        i_opa_i2c_master.start();
        put({OPA_SLV_ADDR, 1'b0}, 1'b1);
        put(a[7:0], 1'b1);
        put(a[15:8], 1'b1);
        foreach (d[i]) begin
            put(d[i], 1'b1);
            if (a >= OPA_PAGE_LO && a <= OPA_PAGE_HI) page_m[a[8:0]] = d[i];
            if (a == OPA_CTRL_ADDR) ctrl_m = d[i][1:0];
            a++;
        end
        i_opa_i2c_master.stop();
    endtask : wr

    task automatic rd(input logic [15:0] a, input int n);
        logic [7:0] none[$];
        wr(a, none);
        i_opa_i2c_master.start();
        put({OPA_SLV_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_opa_i2c_master.xfer(8'hFF, i == n - 1, rx, ack);
            chk("rdata", exp_byte(a + 16'(i)), rx);
        end
        i_opa_i2c_master.stop();
    endtask : rd

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        results();
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        logic [7:0]  q[$];
        logic [7:0]  b;
        logic [15:0] a;
        seed = 32'h1c61d960;
        fail_count = 0;
        check_count = 0;
        ctrl_m = OPA_CTRL_RST;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        chk("plane", 8'h00, {7'h00, plane_sel});
        chk("attr", 8'h00, {7'h00, attr_sel});
        rd(OPA_CTRL_ADDR, 1);
        $display("test reset done");
        repeat (4) begin
            b = 8'($random(seed));
            if (b[7:1] == OPA_SLV_ADDR) b[7:1] = ~b[7:1];
            i_opa_i2c_master.start();
            put(b, 1'b0);
            i_opa_i2c_master.stop();
        end
        $display("test foreign address done");
        for (int t = 0; t < 8; t++) begin
            a = OPA_PAGE_LO | {7'h00, 9'($random(seed))};
            // Burst runs off the page end into unmapped space
            if (t == 3) a = OPA_PAGE_HI - 16'h0001;
            q = {};
            repeat (1 + t % 4) q.push_back(8'($random(seed)));
            wr(a, q);
            rd(a, q.size());
        end
        $display("test page memory done");
        for (int v = 0; v < 4; v++) begin
            q = {8'hFC | 8'(v)};
            wr(OPA_CTRL_ADDR, q);
            repeat (8) @(posedge clk);
            chk("plane", {7'h00, ctrl_m[0]}, {7'h00, plane_sel});
            chk("attr", {7'h00, ctrl_m[1]}, {7'h00, attr_sel});
            rd(OPA_CTRL_ADDR, 1);
            rd(16'h2FFE, 4);
            repeat (2) begin
                a = {2'b00, 8'($random(seed)), 5'($random(seed)), 1'b0};
                rd(a, 2);
            end
        end
        $display("test font and control done");
        q = {8'h5A, 8'hA5};
        wr(16'h7FFF, q);
        wr(16'h0040, q);
        rd(16'h7FFF, 2);
        rd(16'h0040, 2);
        $display("test dropped writes done");
        results();
    end
endmodule : opa_i2c_access_tb

`default_nettype wire
